//--- verilog/cdbw_defines.vh
// Register map, field positions, reset values and cause codes for the
// debug break and watch unit. Assumes inclusion by bare name.
`ifndef CDBW_DEFINES_VH
`define CDBW_DEFINES_VH

// Register offsets (word indices, byte address is four times these)
`define CDBW_OFF_READ_THREAD 8'h13
`define CDBW_OFF_READ_REG 8'h14
`define CDBW_OFF_CAUSE 8'h15
`define CDBW_OFF_PAYLOAD 8'h16
`define CDBW_OFF_HALT 8'h18
`define CDBW_OFF_MAILBOX 8'h20
`define CDBW_OFF_CB_ADDR 8'h30
`define CDBW_OFF_CB_CTRL 8'h40
`define CDBW_OFF_DW_ADDR1 8'h50
`define CDBW_OFF_DW_ADDR2 8'h60
`define CDBW_OFF_DW_CTRL 8'h70
`define CDBW_OFF_RW_MASK 8'h80
`define CDBW_OFF_RW_VALUE 8'h90
`define CDBW_OFF_RW_CTRL 8'h9C

// Control and cause field positions
`define CDBW_BIT_ENABLE 0
`define CDBW_BIT_COND 1
`define CDBW_BIT_LOAD 2
`define CDBW_QUAL_LSB 16
`define CDBW_QUAL_MSB 23
`define CDBW_UNIT_LSB 16
`define CDBW_UNIT_MSB 17
`define CDBW_THREAD_LSB 8
`define CDBW_THREAD_MSB 15

// Cause codes
`define CDBW_CAUSE_NONE 3'h0
`define CDBW_CAUSE_HOST 3'h1
`define CDBW_CAUSE_CALL 3'h2
`define CDBW_CAUSE_CODE 3'h3
`define CDBW_CAUSE_DATA 3'h4
`define CDBW_CAUSE_RES 3'h5

// Reset values
`define CDBW_CTRL_RESET 32'h0000_0000
`define CDBW_WORD_RESET 32'h0000_0000

// Writable bits of the control registers
`define CDBW_CB_CTRL_MASK 32'h00FF_0003
`define CDBW_DW_CTRL_MASK 32'h00FF_0007
`define CDBW_RW_CTRL_MASK 32'h00FF_0003

`endif

//--- verilog/cdbw_unit.v
// Debug break and watch unit: operand, cause and halt registers, mailbox,
// code breakpoints, data and resource watchpoints.
// Assumes core-side event inputs synchronous to clk, one-cycle pulses.
// Assumes reg_wr and reg_rd never high together; reads answer next cycle.
//
// What this block does
// - Eight-bit writable thread select for debug register read, upper bits zero.
// - Five-bit writable register select for debug register read.
// - Three-bit cause field, reset zero, codes one to five.
// - Two-bit unit number, zero for host or call, lowest unit wins.
// - Eight-bit causing thread number, zero for host requests.
// - Payload captures data address or resource identifier on watch hits.
// - Eight-bit halt vector keeps marked threads stopped after debug return.
// - Eight 32-bit mailbox words shared with external debugger.
// - Four code breakpoints compare their address against program counter.
// - Eight-bit per-thread qualifier in each control, reset zero.
// - Code breakpoint condition bit: zero equal, one not equal.
// - Control bit zero enables unit, reset disabled.
// - Four data watchpoints with first and second address registers.
// - Data watch condition bit: zero AND, one OR.
// - Data watch load bit lets loads trigger the watchpoint.
// - Four 32-bit resource watch mask registers.
// - Four 32-bit resource watch compare value registers.
// - Resource watch control: qualifier, condition select, enable, reset zero.
`timescale 1ns/1ps
`include "cdbw_defines.vh"

module cdbw_unit #(
    parameter NUM_UNITS = 4,
    parameter NUM_WORDS = 8
) (
    input wire clk,
    input wire rst_b,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire pc_valid,
    input wire [31:0] pc_value,
    input wire [7:0] pc_thread,
    input wire mem_valid,
    input wire mem_is_load,
    input wire [31:0] mem_address,
    input wire [7:0] mem_thread,
    input wire res_valid,
    input wire [31:0] res_id,
    input wire [7:0] res_thread,
    input wire host_request,
    input wire call_valid,
    input wire [7:0] call_thread,
    input wire in_debug,
    output reg debug_irq,
    output wire [7:0] thread_stop,
    output wire [7:0] read_thread_field,
    output wire [4:0] read_register_field
);

    // ----------------------------------------------------------------
    // Reset synchroniser
    // ----------------------------------------------------------------
    reg rst_meta_reg;
    reg rst_sync_reg;

    // Release reset through two flops
    // Raw release could meet some flops just before an edge, so it is retimed
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // Retimed reset, the only one the rest of the block sees
    wire rst_n = rst_sync_reg;

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    // Operand, cause record and halt state
    reg [7:0] thread_sel_reg;
    reg [4:0] regnum_sel_reg;
    reg [2:0] cause_reg;
    reg [1:0] unit_reg;
    reg [7:0] cause_thread_reg;
    reg [31:0] payload_reg;
    reg [7:0] halt_reg;

    // Mailbox words and per-unit break and watch registers
    reg [31:0] mailbox_reg [0:NUM_WORDS-1];
    reg [31:0] cb_addr_reg [0:NUM_UNITS-1];
    reg [31:0] cb_ctrl_reg [0:NUM_UNITS-1];
    reg [31:0] dw_addr1_reg [0:NUM_UNITS-1];
    reg [31:0] dw_addr2_reg [0:NUM_UNITS-1];
    reg [31:0] dw_ctrl_reg [0:NUM_UNITS-1];
    reg [31:0] rw_mask_reg [0:NUM_UNITS-1];
    reg [31:0] rw_value_reg [0:NUM_UNITS-1];
    reg [31:0] rw_ctrl_reg [0:NUM_UNITS-1];

    // Operand fields to the core, halt vector released inside the handler
    assign read_thread_field = thread_sel_reg;
    assign read_register_field = regnum_sel_reg;
    assign thread_stop = in_debug ? 8'h00 : halt_reg;

    // ----------------------------------------------------------------
    // Match logic
    // ----------------------------------------------------------------
    // Per-unit hit vectors and scratch conditions
    reg [NUM_UNITS-1:0] cb_hit;
    reg [NUM_UNITS-1:0] dw_hit;
    reg [NUM_UNITS-1:0] rw_hit;
    reg cond_a;
    reg cond_b;
    integer i;

    // Per-unit trigger evaluation
    always @* begin
        cb_hit = {NUM_UNITS{1'b0}};
        dw_hit = {NUM_UNITS{1'b0}};
        rw_hit = {NUM_UNITS{1'b0}};
        cond_a = 1'b0;
        cond_b = 1'b0;
        // Every unit checked each cycle, merged by priority below
        for (i = 0; i < NUM_UNITS; i = i + 1) begin
            // Code breakpoint
            if (pc_valid && cb_ctrl_reg[i][`CDBW_BIT_ENABLE]
                && (pc_thread < 8'h08)
                && cb_ctrl_reg[i][`CDBW_QUAL_LSB + pc_thread[2:0]]) begin
                cb_hit[i] = cb_ctrl_reg[i][`CDBW_BIT_COND] ?
                    (pc_value != cb_addr_reg[i]) : (pc_value == cb_addr_reg[i]);
            end
            // Data watchpoint
            cond_a = (mem_address == dw_addr1_reg[i]);
            cond_b = (mem_address == dw_addr2_reg[i]);
            if (mem_valid && dw_ctrl_reg[i][`CDBW_BIT_ENABLE]
                && (mem_thread < 8'h08)
                && dw_ctrl_reg[i][`CDBW_QUAL_LSB + mem_thread[2:0]]
                && (!mem_is_load || dw_ctrl_reg[i][`CDBW_BIT_LOAD])) begin
                dw_hit[i] = dw_ctrl_reg[i][`CDBW_BIT_COND] ?
                    (cond_a | cond_b) : (cond_a & cond_b);
            end
            // Resource watchpoint
            // Condition A reused; the data hit above is already formed
            cond_a = ((res_id & rw_mask_reg[i]) == (rw_value_reg[i] & rw_mask_reg[i]));
            if (res_valid && rw_ctrl_reg[i][`CDBW_BIT_ENABLE]
                && (res_thread < 8'h08)
                && rw_ctrl_reg[i][`CDBW_QUAL_LSB + res_thread[2:0]]) begin
                rw_hit[i] = rw_ctrl_reg[i][`CDBW_BIT_COND] ? ~cond_a : cond_a;
            end
        end
    end

    // Lowest set unit index
    // Falls to unit three on an empty vector; only called with a hit present
    function [1:0] lowest;
        input [3:0] v;
        begin
            if (v[0]) lowest = 2'h0;
            else if (v[1]) lowest = 2'h1;
            else if (v[2]) lowest = 2'h2;
            else lowest = 2'h3;
        end
    endfunction

    // ----------------------------------------------------------------
    // Event priority and capture
    // ----------------------------------------------------------------
    // Selected event, at most one recorded per cycle
    reg fire;
    reg [2:0] cause_next;
    reg [1:0] unit_next;
    reg [7:0] thread_next;
    reg [31:0] payload_next;
    reg payload_load;

    // Host first, then call, code, data, resource
    always @* begin
        fire = 1'b1;
        cause_next = `CDBW_CAUSE_NONE;
        unit_next = 2'h0;
        thread_next = 8'h00;
        payload_next = 32'h0000_0000;
        payload_load = 1'b0;
        // Nothing is taken while the handler runs
        if (in_debug) begin
            fire = 1'b0;
        end else if (host_request) begin
            cause_next = `CDBW_CAUSE_HOST;
        end else if (call_valid) begin
            cause_next = `CDBW_CAUSE_CALL;
            thread_next = call_thread;
        end else if (|cb_hit) begin
            cause_next = `CDBW_CAUSE_CODE;
            unit_next = lowest(cb_hit);
            thread_next = pc_thread;
        end else if (|dw_hit) begin
            cause_next = `CDBW_CAUSE_DATA;
            unit_next = lowest(dw_hit);
            thread_next = mem_thread;
            payload_next = mem_address;
            payload_load = 1'b1;
        end else if (|rw_hit) begin
            cause_next = `CDBW_CAUSE_RES;
            unit_next = lowest(rw_hit);
            thread_next = res_thread;
            payload_next = res_id;
            payload_load = 1'b1;
        end else begin
            fire = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Register writes and event capture
    // ----------------------------------------------------------------
    // Index bits 1:0 beyond the implemented units select nothing
    wire wr_unit = reg_wr && (reg_addr[1:0] < NUM_UNITS);
    integer k;

    // Hardware capture wins over a same-cycle software write
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            thread_sel_reg <= 8'h00;
            regnum_sel_reg <= 5'h00;
            cause_reg <= `CDBW_CAUSE_NONE;
            unit_reg <= 2'h0;
            cause_thread_reg <= 8'h00;
            payload_reg <= `CDBW_WORD_RESET;
            halt_reg <= 8'h00;
            debug_irq <= 1'b0;
            for (k = 0; k < NUM_WORDS; k = k + 1) begin
                mailbox_reg[k] <= `CDBW_WORD_RESET;
            end
            for (k = 0; k < NUM_UNITS; k = k + 1) begin
                cb_addr_reg[k] <= `CDBW_WORD_RESET;
                cb_ctrl_reg[k] <= `CDBW_CTRL_RESET;
                dw_addr1_reg[k] <= `CDBW_WORD_RESET;
                dw_addr2_reg[k] <= `CDBW_WORD_RESET;
                dw_ctrl_reg[k] <= `CDBW_CTRL_RESET;
                rw_mask_reg[k] <= `CDBW_WORD_RESET;
                rw_value_reg[k] <= `CDBW_WORD_RESET;
                rw_ctrl_reg[k] <= `CDBW_CTRL_RESET;
            end
        end else begin
            // One interrupt pulse per firing cycle
            debug_irq <= fire;
            // Single registers and mailbox words
            if (reg_wr) begin
                case (reg_addr)
                    `CDBW_OFF_READ_THREAD: thread_sel_reg <= reg_wdata[7:0];
                    `CDBW_OFF_READ_REG: regnum_sel_reg <= reg_wdata[4:0];
                    `CDBW_OFF_CAUSE: begin
                        cause_reg <= reg_wdata[2:0];
                        cause_thread_reg <= reg_wdata[`CDBW_THREAD_MSB:`CDBW_THREAD_LSB];
                        unit_reg <= reg_wdata[`CDBW_UNIT_MSB:`CDBW_UNIT_LSB];
                    end
                    `CDBW_OFF_PAYLOAD: payload_reg <= reg_wdata;
                    `CDBW_OFF_HALT: halt_reg <= reg_wdata[7:0];
                    default: begin
                        if ({reg_addr[7:3], 3'b000} == `CDBW_OFF_MAILBOX) begin
                            mailbox_reg[reg_addr[2:0]] <= reg_wdata;
                        end
                    end
                endcase
            end
            // Per-unit registers, reserved control bits kept at zero
            if (wr_unit) begin
                case ({reg_addr[7:2], 2'b00})
                    `CDBW_OFF_CB_ADDR: cb_addr_reg[reg_addr[1:0]] <= reg_wdata;
                    `CDBW_OFF_CB_CTRL: cb_ctrl_reg[reg_addr[1:0]] <= reg_wdata & `CDBW_CB_CTRL_MASK;
                    `CDBW_OFF_DW_ADDR1: dw_addr1_reg[reg_addr[1:0]] <= reg_wdata;
                    `CDBW_OFF_DW_ADDR2: dw_addr2_reg[reg_addr[1:0]] <= reg_wdata;
                    `CDBW_OFF_DW_CTRL: dw_ctrl_reg[reg_addr[1:0]] <= reg_wdata & `CDBW_DW_CTRL_MASK;
                    `CDBW_OFF_RW_MASK: rw_mask_reg[reg_addr[1:0]] <= reg_wdata;
                    `CDBW_OFF_RW_VALUE: rw_value_reg[reg_addr[1:0]] <= reg_wdata;
                    `CDBW_OFF_RW_CTRL: rw_ctrl_reg[reg_addr[1:0]] <= reg_wdata & `CDBW_RW_CTRL_MASK;
                    default: ;
                endcase
            end
            // Event record; payload only on watch hits
            if (fire) begin
                cause_reg <= cause_next;
                unit_reg <= unit_next;
                cause_thread_reg <= thread_next;
                if (payload_load) begin
                    payload_reg <= payload_next;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Read port, data one cycle after the strobe
    // ----------------------------------------------------------------
    reg [31:0] rd_mux;

    // Read decode, unmapped reads zero
    always @* begin
        rd_mux = 32'h0000_0000;
        case (reg_addr)
            `CDBW_OFF_READ_THREAD: rd_mux = {24'h00_0000, thread_sel_reg};
            `CDBW_OFF_READ_REG: rd_mux = {27'h000_0000, regnum_sel_reg};
            `CDBW_OFF_CAUSE: rd_mux = {14'h0000, unit_reg, cause_thread_reg, 5'h00, cause_reg};
            `CDBW_OFF_PAYLOAD: rd_mux = payload_reg;
            `CDBW_OFF_HALT: rd_mux = {24'h00_0000, halt_reg};
            default: begin
                // Mailbox first, then per-unit blocks
                if ({reg_addr[7:3], 3'b000} == `CDBW_OFF_MAILBOX) begin
                    rd_mux = mailbox_reg[reg_addr[2:0]];
                end else if (reg_addr[1:0] < NUM_UNITS) begin
                    case ({reg_addr[7:2], 2'b00})
                        `CDBW_OFF_CB_ADDR: rd_mux = cb_addr_reg[reg_addr[1:0]];
                        `CDBW_OFF_CB_CTRL: rd_mux = cb_ctrl_reg[reg_addr[1:0]];
                        `CDBW_OFF_DW_ADDR1: rd_mux = dw_addr1_reg[reg_addr[1:0]];
                        `CDBW_OFF_DW_ADDR2: rd_mux = dw_addr2_reg[reg_addr[1:0]];
                        `CDBW_OFF_DW_CTRL: rd_mux = dw_ctrl_reg[reg_addr[1:0]];
                        `CDBW_OFF_RW_MASK: rd_mux = rw_mask_reg[reg_addr[1:0]];
                        `CDBW_OFF_RW_VALUE: rd_mux = rw_value_reg[reg_addr[1:0]];
                        `CDBW_OFF_RW_CTRL: rd_mux = rw_ctrl_reg[reg_addr[1:0]];
                        default: rd_mux = 32'h0000_0000;
                    endcase
                end
            end
        endcase
    end

    // Registered read data, zero when no read
    // Zero between reads so a stale word never looks like an answer
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule

//--- verif/cdbw_unit_properties.sv
// Port assertions for the debug break and watch unit.
// Assumes binding to cdbw_unit, one clock, rst_b active low.
`timescale 1ns/1ps
module cdbw_unit_properties (
    input wire clk,
    input wire rst_b,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire pc_valid,
    input wire mem_valid,
    input wire res_valid,
    input wire host_request,
    input wire call_valid,
    input wire in_debug,
    input wire debug_irq,
    input wire [7:0] thread_stop,
    input wire [7:0] read_thread_field,
    input wire [4:0] read_register_field
);
    // ----------------------------------------
    // Event and register properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Any core-side event this cycle
    wire any_ev = pc_valid | mem_valid | res_valid | host_request | call_valid;
    sequence halt_wr;
        reg_wr && reg_addr == 8'h18 ##1 !in_debug;
    endsequence
    sequence host_take;
        host_request && !in_debug;
    endsequence
    irq_cause_a: assert property (debug_irq |-> $past(any_ev) && !$past(in_debug))
        else $error("irq without an event");
    host_irq_a: assert property (host_take |=> debug_irq)
        else $error("host request lost");
    call_irq_a: assert property (call_valid && !in_debug |=> debug_irq)
        else $error("debug call lost");
    irq_pulse_a: assert property (host_take ##1 !any_ev |=> !debug_irq)
        else $error("irq longer than one cycle");
    debug_mute_a: assert property (in_debug |=> !debug_irq)
        else $error("event taken inside handler");
    stop_masked_a: assert property (in_debug |-> thread_stop == 8'h00)
        else $error("threads stopped inside handler");
    halt_write_a: assert property (halt_wr |-> thread_stop == $past(reg_wdata[7:0]))
        else $error("halt vector not applied");
    thread_sel_a: assert property (reg_wr && reg_addr == 8'h13 |=>
        read_thread_field == $past(reg_wdata[7:0])) else $error("thread select wrong");
    reg_sel_a: assert property (reg_wr && reg_addr == 8'h14 |=>
        read_register_field == $past(reg_wdata[4:0])) else $error("register select wrong");
endmodule

bind cdbw_unit cdbw_unit_properties chk_u (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
    .pc_valid, .mem_valid, .res_valid, .host_request, .call_valid, .in_debug,
    .debug_irq, .thread_stop, .read_thread_field, .read_register_field);

//--- verif/cdbw_core_model.sv
// Core pipeline and debugger model: one-cycle event pulses, handler level.
// Assumes tasks are called from the bench just after a rising edge.
`timescale 1ns/1ps
module cdbw_core_model (
    input wire clk,
    output wire pc_valid,
    output wire [31:0] pc_value,
    output wire [7:0] pc_thread,
    output wire mem_valid,
    output wire mem_is_load,
    output wire [31:0] mem_address,
    output wire [7:0] mem_thread,
    output wire res_valid,
    output wire [31:0] res_id,
    output wire [7:0] res_thread,
    output wire host_request,
    output wire call_valid,
    output wire [7:0] call_thread,
    output reg in_debug
);
    reg [4:0] vld;
    reg [31:0] dat;
    reg [7:0] thr;
    reg load;
    // Shared value and thread lines fan out to every path
    assign {call_valid, host_request, res_valid, mem_valid, pc_valid} = vld;
    assign {pc_value, mem_address, res_id} = {3{dat}};
    assign {pc_thread, mem_thread, res_thread, call_thread} = {4{thr}};
    assign mem_is_load = load;
    // Idle at time zero
    initial begin
        vld = 5'h00;
        dat = 32'h0;
        thr = 8'h0;
        load = 1'b0;
        in_debug = 1'b0;
    end
    // Pulse of kind k: 0 pc, 1 memory, 2 resource, 3 host, 4 call
    task fire(input [2:0] k, input [31:0] v, input [7:0] t, input ld);
        begin
            @(posedge clk);
            vld <= 5'h01 << k;
            dat <= v;
            thr <= t;
            load <= ld;
            @(posedge clk);
            vld <= 5'h00;
            dat <= ~v; // Idle lines scrambled, not held
            thr <= ~t;
            load <= ~ld;
        end
    endtask
    // Enter or leave the debug handler
    task dbg(input v);
        begin
            @(posedge clk);
            in_debug <= v;
        end
    endtask
endmodule

//--- verif/cdbw_unit_tb.sv
// Bench for the debug break and watch unit: registers and debug events.
// Assumes cdbw_core_model on the core side and a 100 MHz clock.
`timescale 1ns/1ps
module cdbw_unit_tb;
    reg clk;
    reg rst_b;
    reg reg_wr;
    reg reg_rd;
    reg [7:0] reg_addr;
    reg [7:0] i;
    reg [31:0] reg_wdata;
    reg [31:0] e;
    wire [31:0] reg_rdata, pc_value, mem_address, res_id;
    wire pc_valid, mem_valid, mem_is_load, res_valid, host_request, call_valid;
    wire in_debug, debug_irq;
    wire [7:0] pc_thread, mem_thread, res_thread, call_thread, thread_stop;
    wire [7:0] read_thread_field;
    wire [4:0] read_register_field;
    integer n_fail, checks_done, cycles;
    cdbw_unit dut_u (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .pc_valid, .pc_value, .pc_thread, .mem_valid, .mem_is_load, .mem_address,
        .mem_thread, .res_valid, .res_id, .res_thread, .host_request, .call_valid,
        .call_thread, .in_debug, .debug_irq, .thread_stop, .read_thread_field,
        .read_register_field);
    cdbw_core_model core_u (.clk, .pc_valid, .pc_value, .pc_thread, .mem_valid,
        .mem_is_load, .mem_address, .mem_thread, .res_valid, .res_id, .res_thread,
        .host_request, .call_valid, .call_thread, .in_debug);
    // ----------------------------------------
    // Access and compare tasks
    // ----------------------------------------
    task chk(input [31:0] s, input [31:0] x);
        begin
            checks_done = checks_done + 1;
            if (s !== x) begin
                n_fail = n_fail + 1;
                $display("unexpected at %0t: seen %h expected %h", $time, s, x);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge clk);
            reg_wr <= 1'b0;
            @(posedge clk);
        end
    endtask
    task rc(input [7:0] a, input [31:0] x);
        begin
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge clk);
            reg_rd <= 1'b0;
            #1 chk(reg_rdata, x);
            @(posedge clk);
        end
    endtask
    // Write all ones, read back the implemented bits
    task wrc(input [7:0] a, input [31:0] x);
        begin
            wr(a, 32'hFFFFFFFF);
            rc(a, x);
        end
    endtask
    // Fire one event, check the irq and the cause record
    task ev(input [2:0] k, input [31:0] v, input [7:0] t, input ld, input [31:0] x);
        begin
            core_u.fire(k, v, t, ld);
            #1 chk({31'h0, debug_irq}, {31'h0, x != 32'h0});
            @(posedge clk);
            if (x != 32'h0) rc(8'h15, x);
        end
    endtask
    // Address class: 0 unmapped, 1 plain word, 2 control
    function [1:0] cls(input [7:0] a);
        cls = a[7:3] == 5'h04 ? 2'h1 : a[3:2] != 2'h0 ? 2'h0 :
            (a[7:4] == 4'h4 || a[7:4] == 4'h7) ? 2'h2 :
            (a[7:4] == 4'h3 || a[7:4] == 4'h5 || a[7:4] == 4'h6 || a[7:4] >= 4'h8) ? 2'h1 : 2'h0;
    endfunction
    task end_of_test;
        begin
            $display("comparisons %0d mismatches %0d", checks_done, n_fail);
            if (n_fail == 0 && checks_done > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    // ----------------------------------------
    // Clock, timeout and test sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            n_fail = n_fail + 1;
            end_of_test;
        end
    end
    initial begin
        {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata} = 0;
        {n_fail, checks_done, cycles} = 0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        rc(8'h15, 32'h0);
        for (i = 8'h0; i < 8'h4; i = i + 8'h1) begin
            rc(8'h40 + i, 32'h0);
            rc(8'h70 + i, 32'h0);
            rc(8'h9C + i, 32'h0);
        end
        wrc(8'h13, 32'h000000FF);
        wrc(8'h14, 32'h0000001F);
        wrc(8'h15, 32'h0003FF07);
        wrc(8'h18, 32'h000000FF);
        wrc(8'h40, 32'h00FF0003);
        wrc(8'h70, 32'h00FF0007);
        wrc(8'h9C, 32'h00FF0003);
        chk({24'h0, read_thread_field}, 32'hFF);
        chk({27'h0, read_register_field}, 32'h1F);
        chk({24'h0, thread_stop}, 32'hFF);
        wr(8'h40, 32'h0);
        wr(8'h70, 32'h0);
        wr(8'h9C, 32'h0);
        // Plain words keep distinct values, holes read zero
        for (i = 8'h20; i < 8'h9C; i = i + 8'h1)
            if (cls(i) != 2'h2) wr(i, {~i, i, 8'h5A, i});
        for (i = 8'h20; i < 8'h9C; i = i + 8'h1) begin
            e = cls(i) == 2'h1 ? {~i, i, 8'h5A, i} : 32'h0;
            if (cls(i) != 2'h2) rc(i, e);
        end
        // Code breakpoints: qualifier, condition, lowest unit, enable
        wr(8'h31, 32'h1000);
        wr(8'h41, 32'h00040001);
        ev(3'h0, 32'h1000, 8'h02, 1'b0, 32'h00010203);
        ev(3'h0, 32'h1000, 8'h03, 1'b0, 32'h0);
        wr(8'h41, 32'h00040003);
        wr(8'h33, 32'h1004);
        wr(8'h43, 32'h00040001);
        ev(3'h0, 32'h1000, 8'h02, 1'b0, 32'h0);
        ev(3'h0, 32'h1004, 8'h02, 1'b0, 32'h00010203);
        wr(8'h41, 32'h0);
        ev(3'h0, 32'h1004, 8'h02, 1'b0, 32'h00030203);
        wr(8'h43, 32'h0);
        // Data watchpoint 3: OR, load gating, AND
        wr(8'h53, 32'h400);
        wr(8'h63, 32'h800);
        wr(8'h73, 32'h00010003);
        ev(3'h1, 32'h800, 8'h00, 1'b0, 32'h00030004);
        rc(8'h16, 32'h800);
        ev(3'h1, 32'h400, 8'h00, 1'b1, 32'h0);
        wr(8'h73, 32'h00010007);
        ev(3'h1, 32'h400, 8'h00, 1'b1, 32'h00030004);
        wr(8'h73, 32'h00010005);
        ev(3'h1, 32'h400, 8'h00, 1'b0, 32'h0);
        wr(8'h73, 32'h0);
        // Resource watchpoint 1: masked match, qualifier, inverted condition
        wr(8'h81, 32'h0000FF00);
        wr(8'h91, 32'h00003400);
        wr(8'h9D, 32'h00800001);
        ev(3'h2, 32'h12AB34CD, 8'h07, 1'b0, 32'h00010705);
        rc(8'h16, 32'h12AB34CD);
        ev(3'h2, 32'h12AB35CD, 8'h07, 1'b0, 32'h0);
        ev(3'h2, 32'h12AB34CD, 8'h06, 1'b0, 32'h0);
        wr(8'h9D, 32'h00800003);
        ev(3'h2, 32'h12AB35CD, 8'h07, 1'b0, 32'h00010705);
        // Host and call causes, then halt vector around the handler
        ev(3'h3, 32'h0, 8'h09, 1'b0, 32'h00000001);
        ev(3'h4, 32'h0, 8'h05, 1'b0, 32'h00000502);
        wr(8'h18, 32'h5A);
        core_u.dbg(1'b1);
        #1 chk({24'h0, thread_stop}, 32'h0);
        ev(3'h3, 32'h0, 8'h00, 1'b0, 32'h0);
        core_u.dbg(1'b0);
        #1 chk({24'h0, thread_stop}, 32'h5A);
        end_of_test;
    end
endmodule
